// ===== shared/fcm_pkg.sv
// fcm_pkg: command codes, chip states, output pointer codes and carrier structs
// for the flash command decoder; shared by the decoder and its two helpers.
//
// Notes on behaviour
// - command FFH selects array read, 70H selects status read, 90H or 98H selects id/query.
// - in any setup, buffer-load, confirm or bulk factory program state every command selects status, except 03H in lock setup, which selects array read.
// - clear-status 50H in ready, suspended or busy states leaves the output selection alone.
// - completion of a sequencer operation never moves the output selection.
// - any code outside the allowed command set is treated as illegal unless written in a setup, buffer-load, confirm or bulk factory program state.
// - an array read of a partition busy with an internal operation returns invalid data.
// - while program is suspended, erase setup 20H followed by D0H has its second cycle ignored.
// - clear-status resets error flags only while the sequencer is idle and not in a busy mode.
// - bulk factory program data writes are taken only while status bit 0 reads 0.
// - each partition keeps its own output pointer, and the chip next state ignores pointers.
// - lock, lock-down and configuration confirm codes perform the operation then go ready.
// - the block address of a command's first write cycle is latched for the operation when written in ready state; in busy state only a suspend latches it.
package fcm_pkg;

  localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;
  localparam logic [7:0] CMD_WORD_PGM_A   = 8'h10;
  localparam logic [7:0] CMD_WORD_PGM_B   = 8'h40;
  localparam logic [7:0] CMD_BUF_PGM      = 8'he8;
  localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
  localparam logic [7:0] CMD_BULK_FACTORY_PROGRAM_SETUP   = 8'h30;
  localparam logic [7:0] CMD_CONFIRM      = 8'hd0;
  localparam logic [7:0] CMD_SUSPEND      = 8'hb0;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_READ_ID      = 8'h90;
  localparam logic [7:0] CMD_READ_QUERY   = 8'h98;
  localparam logic [7:0] CMD_LOCK_SETUP   = 8'h60;
  localparam logic [7:0] CMD_OTP_SETUP    = 8'hc0;
  localparam logic [7:0] CMD_LOCK_BLOCK   = 8'h01;
  localparam logic [7:0] CMD_LOCK_DOWN    = 8'h2f;
  localparam logic [7:0] CMD_WRITE_CFG    = 8'h03;

  localparam int          STATUS_BULK_FACTORY_PROGRAM_BIT = 0;
  localparam logic [15:0] INVALID_DATA    = 16'hffff;
  localparam int          NUM_PART        = 8;
  localparam int          PART_W          = 3;
  localparam int          BLOCK_W         = 10;
  localparam int          BUF_WORDS       = 32;

  typedef enum logic [1:0] {
    FCM_OUT_ARRAY  = 2'h0,
    FCM_OUT_ID     = 2'h1,
    FCM_OUT_STATUS = 2'h2
  } fcm_out_t;

  // chip command states, one-hot
  typedef enum logic [10:0] {
    FCM_ST_READY      = 11'h001,
    FCM_ST_PGM_SETUP  = 11'h002,
    FCM_ST_BP_SETUP   = 11'h004,
    FCM_ST_BP_LOAD    = 11'h008,
    FCM_ST_BP_CONFIRM = 11'h010,
    FCM_ST_ERASE_SET  = 11'h020,
    FCM_ST_BULK_FACTORY_PROGRAM_SET   = 11'h040,
    FCM_ST_BULK_FACTORY_PROGRAM_DATA  = 11'h080,
    FCM_ST_LOCK_SET   = 11'h100,
    FCM_ST_OTP_SET    = 11'h200,
    FCM_ST_BUSY       = 11'h400
  } fcm_state_t;

  typedef struct packed {
    logic [PART_W-1:0]  part;
    logic [BLOCK_W-1:0] block;
    logic [7:0]         code;
  } fcm_cmd_t;

  typedef struct packed {
    logic clear_errors;
    logic lock_block;
    logic lock_down;
    logic write_cfg;
    logic start_op;
    logic bulk_factory_program_data;
  } fcm_act_t;

endpackage

// ===== rtl/fcm_cmd_classify.sv
// fcm_cmd_classify: flags which command codes belong to the allowed set.
// assumes: purely combinational, code is the low byte of a host write.
`timescale 1ns/1ns
module fcm_cmd_classify (
  input  wire logic [7:0] code,
  output logic            legal
);
  always_comb begin
    case (code)
      fcm_pkg::CMD_READ_ARRAY, fcm_pkg::CMD_WORD_PGM_A, fcm_pkg::CMD_WORD_PGM_B,
      fcm_pkg::CMD_BUF_PGM, fcm_pkg::CMD_ERASE_SETUP, fcm_pkg::CMD_BULK_FACTORY_PROGRAM_SETUP,
      fcm_pkg::CMD_CONFIRM, fcm_pkg::CMD_SUSPEND, fcm_pkg::CMD_READ_STATUS,
      fcm_pkg::CMD_CLEAR_STATUS, fcm_pkg::CMD_READ_ID, fcm_pkg::CMD_READ_QUERY,
      fcm_pkg::CMD_LOCK_SETUP, fcm_pkg::CMD_OTP_SETUP: legal = 1'b1;
      default: legal = 1'b0;
    endcase
  end
endmodule // fcm_cmd_classify

// ===== rtl/fcm_part_ptr.sv
// fcm_part_ptr: one output pointer per partition, written for wr_part when wr_en is high.
// assumes: sys_rst synchronous active high; one write per cycle at most.
`timescale 1ns/1ns
module fcm_part_ptr #(
  parameter int NUM_PART = fcm_pkg::NUM_PART,
  parameter int PART_W   = fcm_pkg::PART_W
) (
  input  wire logic                core_clk,
  input  wire logic                sys_rst,
  input  wire logic                wr_en,
  input  wire logic [PART_W-1:0]   wr_part,
  input  wire fcm_pkg::fcm_out_t   wr_sel,
  input  wire logic [PART_W-1:0]   rd_part,
  output fcm_pkg::fcm_out_t        rd_sel
);
  initial begin
    if (NUM_PART > (1 << PART_W) || NUM_PART < 1) $error("fcm_part_ptr: bad NUM_PART");
  end

  fcm_pkg::fcm_out_t ptr_reg  [NUM_PART];
  fcm_pkg::fcm_out_t ptr_next [NUM_PART];

  genvar g;
  generate
    for (g = 0; g < NUM_PART; g++) begin : g_ptr
      always_comb begin
        ptr_next[g] = ptr_reg[g];
        if (wr_en && wr_part == PART_W'(g)) begin
          ptr_next[g] = wr_sel;
        end
      end
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          ptr_reg[g] <= fcm_pkg::FCM_OUT_ARRAY;
        end else begin
          ptr_reg[g] <= ptr_next[g];
        end
      end
    end
  endgenerate

  assign rd_sel = (32'(rd_part) < NUM_PART) ? ptr_reg[rd_part] : fcm_pkg::FCM_OUT_ARRAY;
endmodule // fcm_part_ptr

// ===== rtl/fcm_decoder.sv
// fcm_decoder: chip command interpreter and per-partition read source selection.
// assumes: host writes arrive as one-cycle strobes synchronous to core_clk; the
// operation sequencer, array and id/query store live outside and report by ports.
`timescale 1ns/1ns
module fcm_decoder #(
  parameter int NUM_PART  = fcm_pkg::NUM_PART,
  parameter int BUF_WORDS = fcm_pkg::BUF_WORDS
) (
  input  wire logic                           core_clk,
  input  wire logic                           sys_rst,
  input  wire logic                           cmd_wr,
  input  wire fcm_pkg::fcm_cmd_t              cmd,
  input  wire logic [fcm_pkg::PART_W-1:0]     rd_part,
  input  wire logic [15:0]                    array_data,
  input  wire logic [15:0]                    id_data,
  input  wire logic [7:0]                     status_word,
  input  wire logic                           seq_busy,
  input  wire logic                           seq_done,
  input  wire logic [NUM_PART-1:0]            part_busy,
  output logic [15:0]                         rd_data,
  output fcm_pkg::fcm_out_t                   rd_sel,
  output fcm_pkg::fcm_state_t                 chip_state,
  output logic                                pgm_suspended,
  output logic [fcm_pkg::BLOCK_W-1:0]         op_block,
  output fcm_pkg::fcm_act_t                   act,
  output logic                                illegal_cmd
);
  initial begin
    if (BUF_WORDS < 1 || BUF_WORDS > 256) $error("fcm_decoder: bad BUF_WORDS");
  end

  fcm_pkg::fcm_state_t               state_reg, state_next;
  logic                              susp_reg, susp_next;
  logic                              erase_susp_reg, erase_susp_next;
  logic [fcm_pkg::BLOCK_W-1:0]       blk_reg, blk_next;
  logic [7:0]                        cnt_reg, cnt_next;
  fcm_pkg::fcm_act_t                 act_reg, act_next;
  logic                              ill_reg, ill_next;
  logic [15:0]                       rd_reg, rd_next;
  logic                              legal;
  logic                              ptr_we;
  fcm_pkg::fcm_out_t                 ptr_sel;
  fcm_pkg::fcm_out_t                 cur_sel;
  logic                              in_setup;

  fcm_cmd_classify u_class (
    .code  (cmd.code),
    .legal (legal)
  );

  fcm_part_ptr #(
    .NUM_PART (NUM_PART),
    .PART_W   (fcm_pkg::PART_W)
  ) u_ptr (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .wr_en    (ptr_we),
    .wr_part  (cmd.part),
    .wr_sel   (ptr_sel),
    .rd_part  (rd_part),
    .rd_sel   (cur_sel)
  );

  // setup, load, confirm and bulk factory states force status output, except 03H in lock setup
  always_comb begin
    case (state_reg)
      fcm_pkg::FCM_ST_PGM_SETUP, fcm_pkg::FCM_ST_BP_SETUP, fcm_pkg::FCM_ST_BP_LOAD,
      fcm_pkg::FCM_ST_BP_CONFIRM, fcm_pkg::FCM_ST_ERASE_SET, fcm_pkg::FCM_ST_BULK_FACTORY_PROGRAM_SET,
      fcm_pkg::FCM_ST_BULK_FACTORY_PROGRAM_DATA, fcm_pkg::FCM_ST_LOCK_SET,
      fcm_pkg::FCM_ST_OTP_SET: in_setup = 1'b1;
      default:                 in_setup = 1'b0;
    endcase
  end

  // output pointer update; depends on chip state and command code, never on a pointer
  always_comb begin
    ptr_we  = 1'b0;
    ptr_sel = fcm_pkg::FCM_OUT_STATUS;
    if (cmd_wr) begin
      if (in_setup) begin
        ptr_we = 1'b1;
        if (state_reg == fcm_pkg::FCM_ST_LOCK_SET && cmd.code == fcm_pkg::CMD_WRITE_CFG) begin
          ptr_sel = fcm_pkg::FCM_OUT_ARRAY;
        end
      end else begin
        case (cmd.code)
          fcm_pkg::CMD_READ_ARRAY: begin
            ptr_we  = 1'b1;
            ptr_sel = fcm_pkg::FCM_OUT_ARRAY;
          end
          fcm_pkg::CMD_READ_ID, fcm_pkg::CMD_READ_QUERY: begin
            ptr_we  = 1'b1;
            ptr_sel = fcm_pkg::FCM_OUT_ID;
          end
          fcm_pkg::CMD_READ_STATUS, fcm_pkg::CMD_WORD_PGM_A, fcm_pkg::CMD_WORD_PGM_B,
          fcm_pkg::CMD_BUF_PGM, fcm_pkg::CMD_ERASE_SETUP, fcm_pkg::CMD_BULK_FACTORY_PROGRAM_SETUP,
          fcm_pkg::CMD_LOCK_SETUP, fcm_pkg::CMD_OTP_SETUP: ptr_we = 1'b1;
          // confirm, suspend, clear-status and illegal codes keep the pointer
          default: ptr_we = 1'b0;
        endcase
      end
    end
  end

  // chip state machine
  always_comb begin
    state_next      = state_reg;
    susp_next       = susp_reg;
    erase_susp_next = erase_susp_reg;
    blk_next        = blk_reg;
    cnt_next        = cnt_reg;
    act_next        = '0;
    ill_next        = 1'b0;
    if (seq_done && state_reg == fcm_pkg::FCM_ST_BUSY) begin
      state_next = fcm_pkg::FCM_ST_READY;
    end
    if (cmd_wr) begin
      ill_next = !legal && !in_setup;
      case (state_reg)
        fcm_pkg::FCM_ST_READY, fcm_pkg::FCM_ST_BUSY: begin
          if (state_reg == fcm_pkg::FCM_ST_READY || cmd.code == fcm_pkg::CMD_SUSPEND) begin
            blk_next = cmd.block;
          end
          case (cmd.code)
            fcm_pkg::CMD_WORD_PGM_A, fcm_pkg::CMD_WORD_PGM_B: begin
              if (!seq_busy) state_next = fcm_pkg::FCM_ST_PGM_SETUP;
            end
            fcm_pkg::CMD_BUF_PGM: begin
              if (!seq_busy) state_next = fcm_pkg::FCM_ST_BP_SETUP;
            end
            fcm_pkg::CMD_ERASE_SETUP: begin
              if (!seq_busy) state_next = fcm_pkg::FCM_ST_ERASE_SET;
            end
            fcm_pkg::CMD_BULK_FACTORY_PROGRAM_SETUP: begin
              if (!seq_busy && !susp_reg) state_next = fcm_pkg::FCM_ST_BULK_FACTORY_PROGRAM_SET;
            end
            fcm_pkg::CMD_LOCK_SETUP: begin
              if (!seq_busy) state_next = fcm_pkg::FCM_ST_LOCK_SET;
            end
            fcm_pkg::CMD_OTP_SETUP: begin
              if (!seq_busy && !susp_reg) state_next = fcm_pkg::FCM_ST_OTP_SET;
            end
            fcm_pkg::CMD_SUSPEND: begin
              if (seq_busy) begin
                susp_next       = !erase_susp_reg;
                erase_susp_next = 1'b1;
                state_next      = fcm_pkg::FCM_ST_READY;
              end
            end
            fcm_pkg::CMD_CONFIRM: begin
              if (susp_reg || erase_susp_reg) begin
                susp_next       = 1'b0;
                erase_susp_next = susp_reg ? erase_susp_reg : 1'b0;
                state_next      = fcm_pkg::FCM_ST_BUSY;
                act_next.start_op = 1'b1;
              end
            end
            fcm_pkg::CMD_CLEAR_STATUS: begin
              act_next.clear_errors = !seq_busy && state_reg == fcm_pkg::FCM_ST_READY;
            end
            default: ;
          endcase
        end
        fcm_pkg::FCM_ST_PGM_SETUP: begin
          state_next        = fcm_pkg::FCM_ST_BUSY;
          act_next.start_op = 1'b1;
        end
        fcm_pkg::FCM_ST_BP_SETUP: begin
          cnt_next   = cmd.code;
          state_next = fcm_pkg::FCM_ST_BP_LOAD;
        end
        fcm_pkg::FCM_ST_BP_LOAD: begin
          if (cnt_reg == 8'h00) state_next = fcm_pkg::FCM_ST_BP_CONFIRM;
          else                  cnt_next   = cnt_reg - 8'h01;
        end
        fcm_pkg::FCM_ST_BP_CONFIRM: begin
          state_next        = (cmd.code == fcm_pkg::CMD_CONFIRM) ? fcm_pkg::FCM_ST_BUSY
                                                                 : fcm_pkg::FCM_ST_READY;
          act_next.start_op = (cmd.code == fcm_pkg::CMD_CONFIRM);
        end
        fcm_pkg::FCM_ST_ERASE_SET: begin
          // while program is suspended the erase confirm is ambiguous: ignore it
          if (susp_reg) begin
            state_next = fcm_pkg::FCM_ST_READY;
          end else if (cmd.code == fcm_pkg::CMD_CONFIRM) begin
            state_next        = fcm_pkg::FCM_ST_BUSY;
            act_next.start_op = 1'b1;
          end else begin
            state_next = fcm_pkg::FCM_ST_READY;
          end
        end
        fcm_pkg::FCM_ST_BULK_FACTORY_PROGRAM_SET: begin
          state_next = (cmd.code == fcm_pkg::CMD_CONFIRM) ? fcm_pkg::FCM_ST_BULK_FACTORY_PROGRAM_DATA
                                                          : fcm_pkg::FCM_ST_READY;
        end
        fcm_pkg::FCM_ST_BULK_FACTORY_PROGRAM_DATA: begin
          if (cmd.block != blk_reg) begin
            state_next = fcm_pkg::FCM_ST_READY;
          end else begin
            act_next.bulk_factory_program_data = !status_word[fcm_pkg::STATUS_BULK_FACTORY_PROGRAM_BIT];
          end
        end
        fcm_pkg::FCM_ST_LOCK_SET: begin
          state_next         = fcm_pkg::FCM_ST_READY;
          act_next.lock_block = (cmd.code == fcm_pkg::CMD_LOCK_BLOCK);
          act_next.lock_down  = (cmd.code == fcm_pkg::CMD_LOCK_DOWN);
          act_next.write_cfg  = (cmd.code == fcm_pkg::CMD_WRITE_CFG);
        end
        fcm_pkg::FCM_ST_OTP_SET: begin
          state_next        = fcm_pkg::FCM_ST_BUSY;
          act_next.start_op = 1'b1;
        end
        default: state_next = fcm_pkg::FCM_ST_READY;
      endcase
    end
  end

  // read data path; a busy partition never shows array contents
  always_comb begin
    case (cur_sel)
      fcm_pkg::FCM_OUT_ARRAY:  rd_next = part_busy[rd_part] ? fcm_pkg::INVALID_DATA
                                                            : array_data;
      fcm_pkg::FCM_OUT_ID:     rd_next = id_data;
      fcm_pkg::FCM_OUT_STATUS: rd_next = {8'h00, status_word};
      default:                 rd_next = fcm_pkg::INVALID_DATA;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_reg      <= fcm_pkg::FCM_ST_READY;
      susp_reg       <= 1'b0;
      erase_susp_reg <= 1'b0;
      blk_reg        <= '0;
      cnt_reg        <= 8'h00;
      act_reg        <= '0;
      ill_reg        <= 1'b0;
      rd_reg         <= 16'h0000;
    end else begin
      state_reg      <= state_next;
      susp_reg       <= susp_next;
      erase_susp_reg <= erase_susp_next;
      blk_reg        <= blk_next;
      cnt_reg        <= cnt_next;
      act_reg        <= act_next;
      ill_reg        <= ill_next;
      rd_reg         <= rd_next;
    end
  end

  assign rd_data       = rd_reg;
  assign rd_sel        = cur_sel;
  assign chip_state    = state_reg;
  assign pgm_suspended = susp_reg;
  assign op_block      = blk_reg;
  assign act           = act_reg;
  assign illegal_cmd   = ill_reg;

  a_setup_forces_status: assert property (@(posedge core_clk) disable iff (sys_rst)
    (cmd_wr && in_setup && !(state_reg == fcm_pkg::FCM_ST_LOCK_SET
      && cmd.code == fcm_pkg::CMD_WRITE_CFG) && rd_part == cmd.part)
    |=> rd_sel == fcm_pkg::FCM_OUT_STATUS)
    else $error("setup-state command did not select status");

  a_clear_keeps_ptr: assert property (@(posedge core_clk) disable iff (sys_rst)
    (cmd_wr && !in_setup && cmd.code == fcm_pkg::CMD_CLEAR_STATUS && rd_part == cmd.part)
    |=> rd_sel == $past(rd_sel))
    else $error("clear-status moved output selection");

  a_done_keeps_ptr: assert property (@(posedge core_clk) disable iff (sys_rst)
    (seq_done && !cmd_wr && $stable(rd_part)) |=> $changed(rd_part) || $stable(rd_sel))
    else $error("operation completion moved output selection");

  a_read_id_sel: assert property (@(posedge core_clk) disable iff (sys_rst)
    (cmd_wr && !in_setup && cmd.code == fcm_pkg::CMD_READ_QUERY && rd_part == cmd.part)
    |=> rd_sel == fcm_pkg::FCM_OUT_ID)
    else $error("query command did not select id data");

  a_illegal_flag: assert property (@(posedge core_clk) disable iff (sys_rst)
    (cmd_wr && !in_setup && cmd.code == 8'h77) |=> illegal_cmd)
    else $error("illegal code not flagged");

  a_busy_invalid: assert property (@(posedge core_clk) disable iff (sys_rst)
    (rd_sel == fcm_pkg::FCM_OUT_ARRAY && part_busy[rd_part])
    |=> rd_data == fcm_pkg::INVALID_DATA)
    else $error("busy partition returned array data");

  a_susp_erase_ign: assert property (@(posedge core_clk) disable iff (sys_rst)
    (cmd_wr && state_reg == fcm_pkg::FCM_ST_ERASE_SET && susp_reg)
    |=> state_reg == fcm_pkg::FCM_ST_READY && !act.start_op)
    else $error("erase confirm taken while program suspended");

  a_clear_when_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
    act.clear_errors |-> $past(!seq_busy) && $past(state_reg) == fcm_pkg::FCM_ST_READY)
    else $error("errors cleared while sequencer running");

  a_bulk_factory_program_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
    act.bulk_factory_program_data |-> !$past(status_word[fcm_pkg::STATUS_BULK_FACTORY_PROGRAM_BIT]))
    else $error("bulk data accepted while status bit 0 set");

  a_lock_to_ready: assert property (@(posedge core_clk) disable iff (sys_rst)
    (cmd_wr && state_reg == fcm_pkg::FCM_ST_LOCK_SET) |=> state_reg == fcm_pkg::FCM_ST_READY)
    else $error("lock confirm did not return to ready");

  a_block_latch: assert property (@(posedge core_clk) disable iff (sys_rst)
    (cmd_wr && state_reg == fcm_pkg::FCM_ST_READY) |=> op_block == $past(cmd.block))
    else $error("first-cycle block address not latched");
endmodule // fcm_decoder

// ===== testbench/fcm_host_model.sv
// fcm_host_model: host memory controller issuing one bus write per call.
// assumes: decoder takes a write on the rising core_clk edge with cmd_wr high.
`timescale 1ns/1ns
module fcm_host_model (
  input  wire logic        core_clk,
  output logic             cmd_wr,
  output fcm_pkg::fcm_cmd_t cmd
);
  initial begin
    cmd_wr = 1'b0;
    cmd    = '0;
  end

  // callers keep both cycles of a two-cycle command on one partition
  task automatic write(input fcm_pkg::fcm_cmd_t c);
    @(posedge core_clk);
    cmd_wr <= 1'b1;
    cmd    <= c;
    @(posedge core_clk);
    cmd_wr <= 1'b0;
    // a released bus must not keep showing the last value
    cmd    <= ~c;
  endtask
endmodule // fcm_host_model

// ===== testbench/testbench.sv
// testbench: directed command sequences against fcm_decoder through the host model.
// assumes: sequencer, stores and status are played by the bench on plain ports.
`timescale 1ns/1ns
module testbench;
  logic                core_clk;
  logic                sys_rst;
  logic                cmd_wr;
  fcm_pkg::fcm_cmd_t   cmd;
  logic [2:0]          rd_part;
  logic [15:0]         array_data;
  logic [15:0]         id_data;
  logic [7:0]          status_word;
  logic                seq_busy;
  logic                seq_done;
  logic [7:0]          part_busy;
  logic [15:0]         rd_data;
  fcm_pkg::fcm_out_t   rd_sel;
  fcm_pkg::fcm_state_t chip_state;
  logic                pgm_suspended;
  logic [9:0]          op_block;
  fcm_pkg::fcm_act_t   act;
  logic                illegal_cmd;
  int                  fails;
  int                  check_count;
  int                  cycles;

  fcm_host_model u_host (.core_clk(core_clk), .cmd_wr(cmd_wr), .cmd(cmd));

  fcm_decoder u_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .cmd_wr(cmd_wr), .cmd(cmd),
    .rd_part(rd_part), .array_data(array_data), .id_data(id_data),
    .status_word(status_word), .seq_busy(seq_busy), .seq_done(seq_done),
    .part_busy(part_busy), .rd_data(rd_data), .rd_sel(rd_sel),
    .chip_state(chip_state), .pgm_suspended(pgm_suspended), .op_block(op_block),
    .act(act), .illegal_cmd(illegal_cmd)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // write lands at the taking edge; results are sampled just after it
  task automatic wr(input logic [7:0] c, input logic [2:0] p, input logic [9:0] b);
    @(posedge core_clk) rd_part <= p;
    u_host.write('{part: p, block: b, code: c});
    #1;
  endtask

  task automatic rd(input logic [2:0] p, input logic [15:0] exp);
    @(posedge core_clk) rd_part <= p;
    repeat (2) @(posedge core_clk);
    #1;
    chk("rd_data", rd_data, exp);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ceiling well above the roughly 160 cycles the sequences need
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      end_sim();
    end
  end

  task automatic do_reset;
    @(posedge core_clk) sys_rst <= 1'b1;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    #1;
  endtask

  logic [7:0] lk_code [3] = '{8'h01, 8'h2f, 8'h03};
  initial begin
    sys_rst = 1'b1; rd_part = '0; array_data = 16'h1234; id_data = 16'h0051;
    status_word = 8'h80; seq_busy = 1'b0; seq_done = 1'b0; part_busy = '0;
    fails = 0; check_count = 0; cycles = 0;
    do_reset();
    for (int p = 0; p < 8; p++) begin
      @(posedge core_clk) rd_part <= 3'(p);
      #1;
      chk("rd_sel", rd_sel, fcm_pkg::FCM_OUT_ARRAY);
    end
    chk("chip_state", chip_state, fcm_pkg::FCM_ST_READY);
    $display("test reset done");
    wr(8'h70, 3'h2, 10'h0);
    chk("rd_sel", rd_sel, fcm_pkg::FCM_OUT_STATUS);
    rd(3'h2, 16'h0080);
    rd(3'h3, 16'h1234);
    wr(8'h90, 3'h2, 10'h0);
    rd(3'h2, 16'h0051);
    wr(8'hff, 3'h2, 10'h0);
    wr(8'h98, 3'h3, 10'h0);
    rd(3'h3, 16'h0051);
    rd(3'h2, 16'h1234);
    @(posedge core_clk) part_busy <= 8'h04;
    rd(3'h2, fcm_pkg::INVALID_DATA);
    @(posedge core_clk) part_busy <= '0;
    wr(8'h50, 3'h3, 10'h0);
    chk("clear_errors", act.clear_errors, 1'b1);
    chk("rd_sel", rd_sel, fcm_pkg::FCM_OUT_ID);
    wr(8'h77, 3'h3, 10'h0);
    chk("illegal", illegal_cmd, 1'b1);
    wr(8'h20, 3'h3, 10'h0);
    chk("illegal", illegal_cmd, 1'b0);
    wr(8'hff, 3'h3, 10'h0);
    chk("rd_sel", rd_sel, fcm_pkg::FCM_OUT_STATUS);
    $display("test read source done");
    do_reset();
    wr(8'h40, 3'h4, 10'h0);
    chk("chip_state", chip_state, fcm_pkg::FCM_ST_PGM_SETUP);
    wr(8'hff, 3'h4, 10'h0);
    chk("start_op", act.start_op, 1'b1);
    chk("rd_sel", rd_sel, fcm_pkg::FCM_OUT_STATUS);
    @(posedge core_clk) seq_busy <= 1'b1;
    wr(8'h50, 3'h4, 10'h0);
    chk("clear_errors", act.clear_errors, 1'b0);
    chk("rd_sel", rd_sel, fcm_pkg::FCM_OUT_STATUS);
    // point away from status first, so an automatic switch on completion would show
    wr(8'hff, 3'h4, 10'h0);
    chk("rd_sel", rd_sel, fcm_pkg::FCM_OUT_ARRAY);
    @(posedge core_clk) seq_done <= 1'b1;
    seq_busy <= 1'b0;
    @(posedge core_clk) seq_done <= 1'b0;
    #1;
    chk("chip_state", chip_state, fcm_pkg::FCM_ST_READY);
    chk("rd_sel", rd_sel, fcm_pkg::FCM_OUT_ARRAY);
    $display("test program done");
    for (int i = 0; i < 3; i++) begin
      wr(8'h60, 3'h5, 10'h155 + 10'(i));
      wr(lk_code[i], 3'h5, 10'h0aa);
      chk("op_block", op_block, 10'h155 + 10'(i));
      chk("lock_block", act.lock_block, i == 0);
      chk("lock_down", act.lock_down, i == 1);
      chk("write_cfg", act.write_cfg, i == 2);
      chk("chip_state", chip_state, fcm_pkg::FCM_ST_READY);
      chk("rd_sel", rd_sel, (i == 2) ? fcm_pkg::FCM_OUT_ARRAY : fcm_pkg::FCM_OUT_STATUS);
    end
    $display("test lock done");
    wr(8'h30, 3'h1, 10'h011);
    wr(8'hd0, 3'h1, 10'h011);
    @(posedge core_clk) status_word <= 8'h80;
    wr(8'h5a, 3'h1, 10'h011);
    chk("bulk_factory_program_data", act.bulk_factory_program_data, 1'b1);
    @(posedge core_clk) status_word <= 8'h81;
    wr(8'h5b, 3'h1, 10'h011);
    chk("bulk_factory_program_data", act.bulk_factory_program_data, 1'b0);
    wr(8'h5c, 3'h1, 10'h012);
    chk("chip_state", chip_state, fcm_pkg::FCM_ST_READY);
    $display("test bulk program done");
    wr(8'he8, 3'h7, 10'h020);
    wr(8'h01, 3'h7, 10'h020);
    wr(8'h11, 3'h7, 10'h020);
    wr(8'h22, 3'h7, 10'h020);
    chk("illegal", illegal_cmd, 1'b0);
    chk("chip_state", chip_state, fcm_pkg::FCM_ST_BP_CONFIRM);
    wr(8'hd0, 3'h7, 10'h020);
    chk("start_op", act.start_op, 1'b1);
    chk("rd_sel", rd_sel, fcm_pkg::FCM_OUT_STATUS);
    @(posedge core_clk) seq_done <= 1'b1;
    @(posedge core_clk) seq_done <= 1'b0;
    #1;
    chk("chip_state", chip_state, fcm_pkg::FCM_ST_READY);
    chk("rd_sel", rd_sel, fcm_pkg::FCM_OUT_STATUS);
    $display("test buffered program done");
    wr(8'h40, 3'h6, 10'h0);
    wr(8'h12, 3'h6, 10'h0);
    @(posedge core_clk) seq_busy <= 1'b1;
    wr(8'hb0, 3'h6, 10'h0);
    chk("suspended", pgm_suspended, 1'b1);
    @(posedge core_clk) seq_busy <= 1'b0;
    wr(8'h20, 3'h6, 10'h0);
    wr(8'hd0, 3'h6, 10'h0);
    chk("start_op", act.start_op, 1'b0);
    chk("chip_state", chip_state, fcm_pkg::FCM_ST_READY);
    chk("suspended", pgm_suspended, 1'b1);
    $display("test suspend done");
    end_sim();
  end
endmodule // testbench
